// File: common/sbm_pkg.sv
// Purpose: shared constants, types and decode helpers of the safety I/O bit mapper
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: register offsets are word indices on the plain register port
//
// Overview of operation
// - input mask bit 1 forwards a sub-slot signal, bit 0 drops it
// - selected input signals are packed gapless, ascending, into safe inputs
// - input masks reset to all ones, forwarding every signal
// - input assignment word 00 aaa bbb: aaa top index, bbb bottom index
// - net data split in 32-bit sub-slots: code 0 signals 1-32, code 1 33-64
// - module address word 0s 0x aaaa: segment 5, sub-slot 0/1, address 1-FFFF
// - output range is scattered ascending onto set output mask bits only
// - output masks reset to all ones, placing outputs from bit 0 upward
// - output assignment word 00 aaa bbb selects the safe output range
// - module type follows from which address tables hold the module
// - address, mask and assignment of one index form one mapping
// - one module and sub-slot may appear in several independent entries
`default_nettype none

package sbm_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_ENTRIES = 16;
  localparam int unsigned SLOT_W = 32;
  localparam int unsigned SAFE_W = 64;
  localparam logic [11:0] SAFE_MAX_IDX = 12'h040;

  // ---------------------------------------------------------------
  // module address word fields
  // ---------------------------------------------------------------
  localparam int unsigned ADR_MOD_LSB = 0;
  localparam int unsigned ADR_SLOT_BIT = 16;
  localparam int unsigned ADR_SEG_LSB = 24;
  localparam logic [3:0] SEG_CONTROLLER = 4'h5;
  localparam logic [31:0] ADR_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // mask and assignment word fields
  // ---------------------------------------------------------------
  localparam logic [31:0] FILTER_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] ASSIGN_RST = 32'h0000_0000;
  localparam int unsigned ASG_LO_LSB = 0;
  localparam int unsigned ASG_HI_LSB = 12;
  localparam int unsigned ASG_TOP_LSB = 24;

  // ---------------------------------------------------------------
  // register map (word indices)
  // ---------------------------------------------------------------
  localparam logic [2:0] RGN_IN_ADDR = 3'h0;
  localparam logic [2:0] RGN_IN_FILT = 3'h1;
  localparam logic [2:0] RGN_IN_ASG = 3'h2;
  localparam logic [2:0] RGN_OUT_ADDR = 3'h3;
  localparam logic [2:0] RGN_OUT_FILT = 3'h4;
  localparam logic [2:0] RGN_OUT_ASG = 3'h5;
  localparam logic [6:0] REG_STATUS = 7'h60;
  localparam logic [6:0] REG_TYPE_QUERY = 7'h61;
  localparam logic [6:0] REG_TYPE_RESULT = 7'h62;
  localparam logic [6:0] REG_SAFE_IN_LO = 7'h63;
  localparam logic [6:0] REG_SAFE_IN_HI = 7'h64;
  localparam logic [6:0] REG_ERR_ENTRY = 7'h65;

  // status bits
  localparam int unsigned STAT_IN_ERR = 0;
  localparam int unsigned STAT_OUT_ERR = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam logic [15:0] QUERY_RST = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SBM_TYPE_NONE = 2'h0,
    SBM_TYPE_INPUT = 2'h1,
    SBM_TYPE_OUTPUT = 2'h2,
    SBM_TYPE_BIDIR = 2'h3
  } sbm_mod_type_t;

  typedef enum logic [2:0] {
    SBM_ST_IDLE = 3'b001,
    SBM_ST_IN = 3'b010,
    SBM_ST_OUT = 3'b100
  } sbm_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [31:0] wdata;
  } sbm_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] module_addr;
    logic subslot;
    logic [31:0] data;
  } sbm_frame_t;

  typedef struct packed {
    logic valid;
    logic [15:0] module_addr;
    logic subslot;
  } sbm_tx_req_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // address word check
  function automatic logic entry_valid(input logic [31:0] w);
    entry_valid = (w[31:28] == 4'h0) && (w[27:24] == SEG_CONTROLLER) &&
                  (w[23:17] == 7'h00) && (w[15:0] != 16'h0000);
  endfunction

endpackage

`default_nettype wire

// File: core/sbm_bit_pack.sv
// Purpose: gather and scatter of 32 sub-slot bits under a mask
// Assumes: purely combinational, used once per table entry
// Notes: both directions share the same ascending walk over the mask
`default_nettype none

module sbm_bit_pack (
  // mask
  input wire logic [31:0] mask,
  // gather side
  input wire logic [31:0] ext_src,
  output logic [31:0] ext,
  // scatter side
  input wire logic [31:0] dep_src,
  output logic [31:0] dep,
  // population
  output logic [5:0] cnt,
  output logic [31:0] ones
);

  // -----------------------------------------------------------------
  // ascending walk
  // -----------------------------------------------------------------
  always_comb
  begin
    logic [5:0] k;
    k = 6'h00;
    ext = 32'h0000_0000;
    dep = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      // only set mask bits take part
      if (mask[i])
      begin
        ext[k[4:0]] = ext_src[i];
        dep[i] = dep_src[k[4:0]];
        k = k + 6'h01;
      end
    end
    cnt = k;
  end

  // low cnt bits set, marks the packed field
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_ones
      assign ones[g] = (6'(g) < cnt);
    end
  endgenerate

endmodule

`default_nettype wire

// File: core/sbm_mapper.sv
// Purpose: table driven bit mapper between safety I/O module frames and safe signals
// Assumes: inputs synchronous to clk; one frame or output request at a time
// Notes: a frame or request starts a 16-cycle scan of the tables
`default_nettype none

module sbm_mapper (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire sbm_pkg::sbm_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // frames received from input modules
  input wire sbm_pkg::sbm_frame_t rx_frame,
  output logic rx_ready,
  // output frame requests and answers
  input wire sbm_pkg::sbm_tx_req_t tx_req,
  output logic tx_req_ready,
  output sbm_pkg::sbm_frame_t tx_frame,
  // safe logic program side
  input wire logic [63:0] safe_logic_outputs,
  output logic [63:0] safe_logic_inputs,
  // configuration error summary
  output logic cfg_error
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  sbm_pkg::sbm_state_t state_q;
  sbm_pkg::sbm_state_t state_d;
  logic [3:0] idx_q;
  logic [15:0] cur_mod_q;
  logic cur_slot_q;
  logic [31:0] cur_data_q;
  logic [63:0] out_snap_q;
  logic [31:0] tx_acc_q;
  logic [31:0] tx_acc_d;
  logic [63:0] safe_in_q;
  logic [63:0] safe_in_d;
  logic [1:0] err_q;
  logic [1:0] err_d;
  logic [7:0] err_entry_q;
  logic ready_q;
  logic [31:0] rdata_q;
  sbm_pkg::sbm_frame_t tx_frame_q;
  logic [15:0] query_q;

  // -----------------------------------------------------------------
  // configuration tables
  // -----------------------------------------------------------------
  // the six tables stay separate arrays so each index forms one mapping
  logic [31:0] in_addr_q [sbm_pkg::NUM_ENTRIES];
  logic [31:0] in_filt_q [sbm_pkg::NUM_ENTRIES];
  logic [31:0] in_asg_q [sbm_pkg::NUM_ENTRIES];
  logic [31:0] out_addr_q [sbm_pkg::NUM_ENTRIES];
  logic [31:0] out_filt_q [sbm_pkg::NUM_ENTRIES];
  logic [31:0] out_asg_q [sbm_pkg::NUM_ENTRIES];

  // -----------------------------------------------------------------
  // register decode
  // -----------------------------------------------------------------
  function automatic logic in_region(input logic [6:0] a, input logic [2:0] rgn);
    in_region = (a[6:4] == rgn);
  endfunction

  wire logic [3:0] bus_entry = bus_req.addr[3:0];
  wire logic wr_in_addr = bus_req.wr && in_region(bus_req.addr, sbm_pkg::RGN_IN_ADDR);
  wire logic wr_in_filt = bus_req.wr && in_region(bus_req.addr, sbm_pkg::RGN_IN_FILT);
  wire logic wr_in_asg = bus_req.wr && in_region(bus_req.addr, sbm_pkg::RGN_IN_ASG);
  wire logic wr_out_addr = bus_req.wr && in_region(bus_req.addr, sbm_pkg::RGN_OUT_ADDR);
  wire logic wr_out_filt = bus_req.wr && in_region(bus_req.addr, sbm_pkg::RGN_OUT_FILT);
  wire logic wr_out_asg = bus_req.wr && in_region(bus_req.addr, sbm_pkg::RGN_OUT_ASG);
  wire logic wr_status = bus_req.wr && (bus_req.addr == sbm_pkg::REG_STATUS);
  wire logic wr_query = bus_req.wr && (bus_req.addr == sbm_pkg::REG_TYPE_QUERY);

  genvar e;
  generate
    for (e = 0; e < sbm_pkg::NUM_ENTRIES; e++)
    begin : g_tab
      wire logic hit = (bus_entry == 4'(e));
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          in_addr_q[e] <= sbm_pkg::ADR_RST;
          in_filt_q[e] <= sbm_pkg::FILTER_RST;
          in_asg_q[e] <= sbm_pkg::ASSIGN_RST;
          out_addr_q[e] <= sbm_pkg::ADR_RST;
          out_filt_q[e] <= sbm_pkg::FILTER_RST;
          out_asg_q[e] <= sbm_pkg::ASSIGN_RST;
        end
        else
        begin
          if (wr_in_addr && hit)
            in_addr_q[e] <= bus_req.wdata;
          if (wr_in_filt && hit)
            in_filt_q[e] <= bus_req.wdata;
          if (wr_in_asg && hit)
            in_asg_q[e] <= bus_req.wdata;
          if (wr_out_addr && hit)
            out_addr_q[e] <= bus_req.wdata;
          if (wr_out_filt && hit)
            out_filt_q[e] <= bus_req.wdata;
          if (wr_out_asg && hit)
            out_asg_q[e] <= bus_req.wdata;
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // module type lookup
  // -----------------------------------------------------------------
  logic [sbm_pkg::NUM_ENTRIES-1:0] in_hit_vec;
  logic [sbm_pkg::NUM_ENTRIES-1:0] out_hit_vec;
  generate
    for (e = 0; e < sbm_pkg::NUM_ENTRIES; e++)
    begin : g_type
      assign in_hit_vec[e] = sbm_pkg::entry_valid(in_addr_q[e]) &&
                             (in_addr_q[e][15:0] == query_q);
      assign out_hit_vec[e] = sbm_pkg::entry_valid(out_addr_q[e]) &&
                              (out_addr_q[e][15:0] == query_q);
    end
  endgenerate

  // type from table presence, never configured
  wire sbm_pkg::sbm_mod_type_t mod_type =
    sbm_pkg::sbm_mod_type_t'({|out_hit_vec, |in_hit_vec});

  // -----------------------------------------------------------------
  // current entry of the scan
  // -----------------------------------------------------------------
  wire logic scan_in = (state_q == sbm_pkg::SBM_ST_IN);
  wire logic scan_out = (state_q == sbm_pkg::SBM_ST_OUT);
  // all three words taken from the same index
  wire logic [31:0] sel_addr = scan_in ? in_addr_q[idx_q] : out_addr_q[idx_q];
  wire logic [31:0] sel_filt = scan_in ? in_filt_q[idx_q] : out_filt_q[idx_q];
  wire logic [31:0] sel_asg = scan_in ? in_asg_q[idx_q] : out_asg_q[idx_q];

  // module address and sub-slot must both match
  wire logic sel_match = sbm_pkg::entry_valid(sel_addr) &&
                         (sel_addr[sbm_pkg::ADR_MOD_LSB +: 16] == cur_mod_q) &&
                         (sel_addr[sbm_pkg::ADR_SLOT_BIT] == cur_slot_q);

  wire logic [11:0] rng_lo = sel_asg[sbm_pkg::ASG_LO_LSB +: 12];
  wire logic [11:0] rng_hi = sel_asg[sbm_pkg::ASG_HI_LSB +: 12];
  wire logic [11:0] rng_width = rng_hi - rng_lo + 12'h001;
  wire logic [5:0] rng_shift = rng_lo[5:0] - 6'h01;

  logic [31:0] pk_ext;
  logic [31:0] pk_dep;
  logic [5:0] pk_cnt;
  logic [31:0] pk_ones;

  // out_snap shifted so the range bottom sits at bit 0
  wire logic [63:0] out_shifted = out_snap_q >> rng_shift;

  sbm_bit_pack u_pack (
    .mask(sel_filt),
    .ext_src(cur_data_q),
    .ext(pk_ext),
    .dep_src(out_shifted[31:0]),
    .dep(pk_dep),
    .cnt(pk_cnt),
    .ones(pk_ones)
  );

  // range must be legal and as wide as the mask population
  wire logic rng_ok = (sel_asg[31:sbm_pkg::ASG_TOP_LSB] == 8'h00) &&
                      (rng_lo != 12'h000) && (rng_hi >= rng_lo) &&
                      (rng_hi <= sbm_pkg::SAFE_MAX_IDX) &&
                      (rng_width == {6'h00, pk_cnt});
  wire logic entry_do = sel_match && rng_ok;
  wire logic entry_bad = sel_match && !rng_ok;

  // packed field placed from bbb upward
  wire logic [63:0] in_field = {32'h0000_0000, pk_ext} << rng_shift;
  wire logic [63:0] in_keep = {32'h0000_0000, pk_ones} << rng_shift;

  // -----------------------------------------------------------------
  // scan sequencing
  // -----------------------------------------------------------------
  wire logic scan_last = (idx_q == 4'hF);
  wire logic take_rx = (state_q == sbm_pkg::SBM_ST_IDLE) && rx_frame.valid;
  wire logic take_tx = (state_q == sbm_pkg::SBM_ST_IDLE) && !rx_frame.valid && tx_req.valid;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      sbm_pkg::SBM_ST_IDLE:
      begin
        if (take_rx)
          state_d = sbm_pkg::SBM_ST_IN;
        else if (take_tx)
          state_d = sbm_pkg::SBM_ST_OUT;
      end
      sbm_pkg::SBM_ST_IN,
      sbm_pkg::SBM_ST_OUT:
      begin
        if (scan_last)
          state_d = sbm_pkg::SBM_ST_IDLE;
      end
      default:
        state_d = sbm_pkg::SBM_ST_IDLE;
    endcase
  end

  // every matching entry with a legal range applies, each with its own mask and range
  assign safe_in_d = (scan_in && entry_do) ? ((safe_in_q & ~in_keep) | in_field) : safe_in_q;
  assign tx_acc_d = take_tx ? 32'h0000_0000 :
                    (scan_out && entry_do) ? ((tx_acc_q & ~sel_filt) | pk_dep) : tx_acc_q;

  // errors are sticky, set wins over a write-one clear
  wire logic [1:0] err_set = {scan_out && entry_bad, scan_in && entry_bad};
  wire logic [1:0] err_clr = wr_status ? bus_req.wdata[1:0] : 2'b00;
  assign err_d = (err_q & ~err_clr) | err_set;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= sbm_pkg::SBM_ST_IDLE;
      idx_q <= 4'h0;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= (state_q == sbm_pkg::SBM_ST_IDLE) ? 4'h0 : idx_q + 4'h1;
      ready_q <= (state_d == sbm_pkg::SBM_ST_IDLE);
    end
  end

  // captured frame or request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur_mod_q <= 16'h0000;
      cur_slot_q <= 1'b0;
      cur_data_q <= 32'h0000_0000;
      out_snap_q <= 64'h0000_0000_0000_0000;
    end
    else if (take_rx)
    begin
      cur_mod_q <= rx_frame.module_addr;
      cur_slot_q <= rx_frame.subslot;
      cur_data_q <= rx_frame.data;
    end
    else if (take_tx)
    begin
      cur_mod_q <= tx_req.module_addr;
      cur_slot_q <= tx_req.subslot;
      // snapshot keeps one output frame coherent across the scan
      out_snap_q <= safe_logic_outputs;
    end
  end

  // results
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      safe_in_q <= 64'h0000_0000_0000_0000;
      tx_acc_q <= 32'h0000_0000;
      tx_frame_q <= '0;
      err_q <= 2'b00;
      err_entry_q <= 8'h00;
    end
    else
    begin
      safe_in_q <= safe_in_d;
      tx_acc_q <= tx_acc_d;
      tx_frame_q.valid <= scan_out && scan_last;
      // answer fields hold between answers, the accumulator moves during the scan
      if (scan_out && scan_last)
      begin
        tx_frame_q.module_addr <= cur_mod_q;
        tx_frame_q.subslot <= cur_slot_q;
        tx_frame_q.data <= tx_acc_d;
      end
      err_q <= err_d;
      if (err_set[0])
        err_entry_q[3:0] <= idx_q;
      if (err_set[1])
        err_entry_q[7:4] <= idx_q;
    end
  end

  // -----------------------------------------------------------------
  // register read
  // -----------------------------------------------------------------
  wire logic [3:0] rd_e = bus_req.addr[3:0];
  logic [31:0] rd_val;
  always_comb
  begin
    unique case (bus_req.addr[6:4])
      sbm_pkg::RGN_IN_ADDR: rd_val = in_addr_q[rd_e];
      sbm_pkg::RGN_IN_FILT: rd_val = in_filt_q[rd_e];
      sbm_pkg::RGN_IN_ASG: rd_val = in_asg_q[rd_e];
      sbm_pkg::RGN_OUT_ADDR: rd_val = out_addr_q[rd_e];
      sbm_pkg::RGN_OUT_FILT: rd_val = out_filt_q[rd_e];
      sbm_pkg::RGN_OUT_ASG: rd_val = out_asg_q[rd_e];
      default:
      begin
        if (bus_req.addr == sbm_pkg::REG_STATUS)
          rd_val = {29'h0000_0000, !ready_q, err_q};
        else if (bus_req.addr == sbm_pkg::REG_TYPE_QUERY)
          rd_val = {16'h0000, query_q};
        else if (bus_req.addr == sbm_pkg::REG_TYPE_RESULT)
          rd_val = {30'h0000_0000, mod_type};
        else if (bus_req.addr == sbm_pkg::REG_SAFE_IN_LO)
          rd_val = safe_in_q[31:0];
        else if (bus_req.addr == sbm_pkg::REG_SAFE_IN_HI)
          rd_val = safe_in_q[63:32];
        else if (bus_req.addr == sbm_pkg::REG_ERR_ENTRY)
          rd_val = {24'h00_0000, err_entry_q};
        else
          rd_val = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
      query_q <= sbm_pkg::QUERY_RST;
    end
    else
    begin
      // read data stands for one cycle only
      rdata_q <= bus_req.rd ? rd_val : 32'h0000_0000;
      if (wr_query)
        query_q <= bus_req.wdata[15:0];
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign bus_rdata = rdata_q;
  assign rx_ready = ready_q;
  assign tx_req_ready = ready_q;
  assign tx_frame = tx_frame_q;
  assign safe_logic_inputs = safe_in_q;
  assign cfg_error = |err_q;

endmodule

`default_nettype wire

// File: bench/sbm_mapper_chk.sv
// Purpose: port level checks of the bit mapper
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every sbm_mapper instance
`default_nettype none

module sbm_mapper_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire sbm_pkg::sbm_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  // frames and requests
  input wire sbm_pkg::sbm_frame_t rx_frame,
  input wire logic rx_ready,
  input wire sbm_pkg::sbm_tx_req_t tx_req,
  input wire logic tx_req_ready,
  input wire sbm_pkg::sbm_frame_t tx_frame,
  // safe logic side
  input wire logic [63:0] safe_logic_outputs,
  input wire logic [63:0] safe_logic_inputs,
  input wire logic cfg_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic rx_take = rx_frame.valid && rx_ready;
  wire logic tx_take = tx_req.valid && !rx_frame.valid && tx_req_ready;
  wire logic st_wr = bus_req.wr && (bus_req.addr == sbm_pkg::REG_STATUS);

  chk_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_scan_window: assert property (rx_take |-> ##16 !rx_ready ##1 rx_ready)
    else $error("input scan length wrong");
  chk_scan_busy: assert property (rx_take |=> !tx_req_ready [*8])
    else $error("request ready during scan");
  chk_tx_answer: assert property (tx_take |-> ##17 tx_frame.valid)
    else $error("output frame not answered in time");
  chk_tx_pulse: assert property (tx_frame.valid |=> !tx_frame.valid)
    else $error("output frame valid too long");
  chk_tx_hold: assert property (!tx_frame.valid |-> $stable(tx_frame.data))
    else $error("output data moved without answer");
  chk_in_hold: assert property (rx_ready && $past(rx_ready) |-> $stable(safe_logic_inputs))
    else $error("safe inputs moved while idle");
  chk_err_sticky: assert property (cfg_error && !st_wr |=> cfg_error)
    else $error("error flag dropped without clear");
  chk_err_scan: assert property ($rose(cfg_error) |-> !$past(rx_ready))
    else $error("error flag raised outside scan");
  cover property (rx_take);
  cover property (tx_frame.valid);
  cover property ($rose(cfg_error));
endmodule

bind sbm_mapper sbm_mapper_chk i_sbm_mapper_chk (.clk(clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .rx_frame(rx_frame), .rx_ready(rx_ready), .tx_req(tx_req),
  .tx_req_ready(tx_req_ready), .tx_frame(tx_frame), .safe_logic_outputs(safe_logic_outputs),
  .safe_logic_inputs(safe_logic_inputs), .cfg_error(cfg_error));

`default_nettype wire

// File: bench/sbm_io_model.sv
// Purpose: safety I/O modules on the far side of the mapper
// Assumes: frames and requests wait for the mapper's ready flag
// Notes: released fields show the inverse of the last value
`default_nettype none

module sbm_io_model (
  // clock
  input wire logic clk,
  // mapper side
  input wire logic rx_ready,
  input wire logic tx_req_ready,
  output var sbm_pkg::sbm_frame_t rx_frame,
  output var sbm_pkg::sbm_tx_req_t tx_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    rx_frame = '0;
    tx_req = '0;
  end
  task automatic send(input logic [15:0] m, input logic s, input logic [31:0] d);
    @(posedge clk);
    rx_frame <= '{valid: 1'b1, module_addr: m, subslot: s, data: d};
    @(posedge clk);
    while (rx_ready !== 1'b1)
      @(posedge clk);
    rx_frame <= '{valid: 1'b0, module_addr: ~m, subslot: ~s, data: ~d};
  endtask
  task automatic request(input logic [15:0] m, input logic s);
    @(posedge clk);
    tx_req <= '{valid: 1'b1, module_addr: m, subslot: s};
    @(posedge clk);
    while (tx_req_ready !== 1'b1)
      @(posedge clk);
    tx_req <= '{valid: 1'b0, module_addr: ~m, subslot: ~s};
  endtask
endmodule

`default_nettype wire

// File: bench/sbm_mapper_tb.sv
// Purpose: self-checking bench of the bit mapper against a table model
// Assumes: 50 MHz clock, reset held 12 cycles
// Notes: model keeps its own copy of every table write
`default_nettype none

module sbm_mapper_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sbm_pkg::sbm_bus_req_t bus_req = '0;
  sbm_pkg::sbm_frame_t rx_frame, tx_frame;
  sbm_pkg::sbm_tx_req_t tx_req;
  logic [31:0] bus_rdata, v;
  logic [63:0] safe_logic_outputs = '0;
  logic [63:0] safe_logic_inputs, exp_in;
  logic [31:0] exp_out;
  logic rx_ready, tx_req_ready, cfg_error;
  logic [1:0] err_in;
  logic [7:0] ee;
  logic [31:0] tbl [6][16];
  int fail_count = 0;
  int compares = 0;
  localparam logic [38:0] CFG [14] = '{{7'h05, 32'h05000090}, {7'h15, 32'h000F000F},
    {7'h25, 32'h00008001}, {7'h06, 32'h05000090}, {7'h16, 32'h00000F00}, {7'h26, 32'h0000C009},
    {7'h07, 32'h05000200}, {7'h17, 32'h00000001}, {7'h27, 32'h00010010}, {7'h33, 32'h05010100},
    {7'h43, 32'h00001031}, {7'h53, 32'h00008005}, {7'h34, 32'h05000200},
    {7'h54, 32'h00020001}};
  localparam logic [15:0] QM [4] = '{16'h0090, 16'h0100, 16'h0200, 16'h0123};

  always #10 clk = ~clk;

  sbm_mapper i_sbm_mapper (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .rx_frame(rx_frame), .rx_ready(rx_ready), .tx_req(tx_req), .tx_req_ready(tx_req_ready),
    .tx_frame(tx_frame), .safe_logic_outputs(safe_logic_outputs),
    .safe_logic_inputs(safe_logic_inputs), .cfg_error(cfg_error));
  sbm_io_model i_sbm_io_model (.clk(clk), .rx_ready(rx_ready), .tx_req_ready(tx_req_ready),
    .rx_frame(rx_frame), .tx_req(tx_req));

  task automatic summarize();
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
    if (a[6:4] < 3'h6)
      tbl[a[6:4]][a[3:0]] = d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] q);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus_req <= '0;
    #1;
    q = bus_rdata;
  endtask
  function automatic bit vld(input logic [31:0] w);
    return (w[31:24] == 8'h05) && (w[23:17] == 7'h00) && (w[15:0] != 16'h0000);
  endfunction
  task automatic model_run(input bit o, input logic [15:0] m, input logic s,
      input logic [31:0] d);
    int e, b, k, lo, hi;
    logic [31:0] aw, mw, gw;
    if (o)
      exp_out = '0;
    for (e = 0; e < 16; e++)
    begin
      aw = tbl[o ? 3 : 0][e];
      mw = tbl[o ? 4 : 1][e];
      gw = tbl[o ? 5 : 2][e];
      lo = int'(gw[11:0]);
      hi = int'(gw[23:12]);
      if (!vld(aw) || aw[15:0] != m || aw[16] != s)
        continue;
      if (gw[31:24] != 8'h0 || lo < 1 || lo > hi || hi > 64 || hi - lo + 1 != $countones(mw))
      begin
        err_in[o] = 1'b1;
        if (o)
          ee[7:4] = 4'(e);
        else
          ee[3:0] = 4'(e);
        continue;
      end
      k = 0;
      for (b = 0; b < 32; b++)
        if (mw[b])
        begin
          if (o)
            exp_out[b] = safe_logic_outputs[lo - 1 + k];
          else
            exp_in[lo - 1 + k] = d[b];
          k++;
        end
    end
  endtask
  task automatic op(input bit o, input logic [15:0] m, input logic s, input logic [31:0] d);
    int n;
    if (o)
      i_sbm_io_model.request(m, s);
    else
      i_sbm_io_model.send(m, s, d);
    model_run(o, m, s, d);
    n = 0;
    tick();
    while (((o && tx_frame.valid !== 1'b1) || (!o && rx_ready !== 1'b1)) && n < 40)
    begin
      tick();
      n++;
    end
    if (o)
    begin
      check("tx_data", {32'h0, tx_frame.data}, {32'h0, exp_out});
      check("tx_addr", {47'h0, tx_frame.subslot, tx_frame.module_addr}, {47'h0, s, m});
    end
    else
      check("safe_in", safe_logic_inputs, exp_in);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    int i, r, e;
    logic [1:0] t;
    for (r = 0; r < 6; r++)
      for (i = 0; i < 16; i++)
        tbl[r][i] = (r == 1 || r == 4) ? 32'hFFFF_FFFF : 32'h0;
    exp_in = '0;
    err_in = 2'b00;
    ee = 8'h00;
    void'($urandom(32'hDF92));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(7'h10, v);
    check("in_mask_rst", {32'h0, v}, 64'hFFFF_FFFF);
    rd(7'h4F, v);
    check("out_mask_rst", {32'h0, v}, 64'hFFFF_FFFF);
    rd(7'h7F, v);
    check("unmapped", {32'h0, v}, 64'h0);
    for (i = 0; i < 14; i++)
      wr(CFG[i][38:32], CFG[i][31:0]);
    for (r = 0; r < 3; r++)
    begin
      op(1'b0, 16'h0090, 1'b0, $urandom);
      op(1'b0, 16'h0200, 1'b0, $urandom);
      op(1'b0, 16'h0055, 1'b0, $urandom);
      safe_logic_outputs <= {$urandom, $urandom};
      op(1'b1, 16'h0100, 1'b1, 32'h0);
      op(1'b1, 16'h0200, 1'b0, 32'h0);
    end
    for (i = 0; i < 4; i++)
    begin
      t = 2'h0;
      for (e = 0; e < 16; e++)
      begin
        t[0] = t[0] | (vld(tbl[0][e]) && tbl[0][e][15:0] == QM[i]);
        t[1] = t[1] | (vld(tbl[3][e]) && tbl[3][e][15:0] == QM[i]);
      end
      wr(sbm_pkg::REG_TYPE_QUERY, {16'h0, QM[i]});
      rd(sbm_pkg::REG_TYPE_RESULT, v);
      check("mod_type", {32'h0, v}, {62'h0, t});
    end
    wr(7'h08, 32'h05000090);
    wr(7'h18, 32'h00000003);
    wr(7'h28, 32'h00003001);
    op(1'b0, 16'h0090, 1'b0, $urandom);
    check("cfg_error", {63'h0, cfg_error}, {63'h0, |err_in});
    rd(sbm_pkg::REG_STATUS, v);
    check("status", {32'h0, v}, {62'h0, err_in});
    rd(sbm_pkg::REG_ERR_ENTRY, v);
    check("err_entry", {32'h0, v}, {56'h0, ee});
    wr(sbm_pkg::REG_STATUS, 32'h0000_0003);
    tick();
    tick();
    check("err_clear", {63'h0, cfg_error}, 64'h0);
    summarize();
  end
endmodule

`default_nettype wire
